/* File: design/pll_cfg_defs.svh */
// Offsets, field positions, reset values and sizes of the loop cfg bank.
// Assumes inclusion by bare name from the design directory.
`ifndef PLL_CFG_DEFS_SVH
`define PLL_CFG_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_FREQ_CONTROL_MODE 6'h04
`define IDX_INPUT_PIN_GATES 6'h05
`define IDX_OSC_SWING_SELECT 6'h06
`define IDX_OSC_LOAD_TRIM 6'h07
`define IDX_SLOT_ZERO 6'h08
`define IDX_SLOT_ONE 6'h09
`define IDX_SLOT_TWO 6'h0a
`define IDX_SLOT_THREE 6'h0b

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FREQ_CONTROL_MODE 8'h00
`define RST_INPUT_PIN_GATES 8'hff
`define RST_OSC_SWING_SELECT 8'h30
`define RST_OSC_LOAD_TRIM 8'h00
`define RST_SLOT 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define POS_MODE_BIT 0
`define POS_GATE_LSB 0
`define POS_GATE_MSB 5
`define POS_SWING_LSB 4
`define POS_SWING_MSB 5
`define POS_ODIV_BIT 7
`define POS_PUMP_LSB 4
`define POS_PUMP_MSB 6
`define POS_RES_LSB 0
`define POS_RES_MSB 3

// ****************************************************************
// Sizes
// ****************************************************************
`define NUM_SLOTS 4
`define NUM_GIN 6
`define SLOT_ZERO_SEL 2'h0

`endif

/* File: design/pll_cfg_pkg.sv */
// Types shared by the loop cfg bank files.
// Assumes nothing of its surroundings.
`default_nettype none

package pll_cfg_pkg;

  // Oscillator swing codes
  typedef enum logic [1:0] {
    SWING_LOW = 2'b00,
    SWING_MED = 2'b01,
    SWING_HIGH = 2'b10,
    SWING_EXT_CLK = 2'b11
  } osc_swing_t;

  // Index of a loop filter setting slot
  typedef logic [1:0] slot_idx_t;

  // One register byte
  typedef logic [7:0] cfg_byte_t;

endpackage

`default_nettype wire

/* File: design/cfg_slot_mem.sv */
// Four-entry store for the loop filter setting slots.
// Assumes one writer; both read ports give registered data one edge later.
`default_nettype none
`include "pll_cfg_defs.svh"

module cfg_slot_mem
  import pll_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire pll_cfg_pkg::slot_idx_t wr_idx,
  input wire pll_cfg_pkg::cfg_byte_t wr_data,
  // Bus read port
  input wire pll_cfg_pkg::slot_idx_t rd_idx_a,
  output pll_cfg_pkg::cfg_byte_t rd_data_a_r,
  // Active slot read port
  input wire pll_cfg_pkg::slot_idx_t rd_idx_b,
  output pll_cfg_pkg::cfg_byte_t rd_data_b_r
);

  // Slot contents
  cfg_byte_t mem_r [`NUM_SLOTS];

  // ****************************************************************
  // Storage, each entry cleared at reset
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_SLOTS; g++) begin : g_entry
      // Entry write
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[g] <= `RST_SLOT;
        end else if (wr_en && (wr_idx == slot_idx_t'(g))) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Registered read ports
  // ****************************************************************
  // Bus side read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_a_r <= `RST_SLOT;
    end else begin
      rd_data_a_r <= mem_r[rd_idx_a];
    end
  end

  // Active slot read feeding the loop controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_b_r <= `RST_SLOT;
    end else begin
      rd_data_b_r <= mem_r[rd_idx_b];
    end
  end

endmodule

`default_nettype wire

/* File: design/pll_input_and_loop_cfg_regs.sv */
// APB register bank for frequency mode, input gates, oscillator and the
// four loop filter slots of the first synthesizer loop.
// Assumes an APB master on pclk; general input pins are asynchronous.
//
// Functional notes
// - Mode bit zero: 0 all loops, 1 first
// - Six gate bits, default 1, 0 forces low
// - Swing code bits 5:4, reset 0x30
// - Eight-bit load trim code, default zero
// - Four slots: divider, pump, resistor, reset zero
// - Pins disabled in mode: use slot zero
// - Active slot divider bit picks divider setting
// - Resistor code drives loop resistance linearly
// - Pump code drives binary weighted current
`default_nettype none
`include "pll_cfg_defs.svh"

module pll_input_and_loop_cfg_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // General input pins, raw and gated
  input wire logic [5:0] general_input_pins,
  output logic [5:0] gated_input_pins,
  // Frequency control and gates
  output logic manual_freq_select_mode,
  output logic [5:0] input_pin_gate,
  // Oscillator controls
  output pll_cfg_pkg::osc_swing_t osc_swing_select,
  output logic osc_ext_clock_sel,
  output logic [7:0] osc_load_trim,
  // First synthesizer loop controls
  output pll_cfg_pkg::slot_idx_t active_slot,
  output logic out_divider_choice,
  output logic [2:0] pump_current_code,
  output logic [3:0] loop_resistor_code
);

  import pll_cfg_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Register storage for the four plain locations
  cfg_byte_t mode_r;
  cfg_byte_t gates_r;
  cfg_byte_t swing_r;
  cfg_byte_t trim_r;
  // Bus handshake registers
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  // Word index from the byte address
  logic [5:0] idx;
  // Address maps to a register and is word aligned
  logic hit;
  // Address maps to one of the slots
  logic slot_hit;
  // Access phase is ending at this edge
  logic xfer_done;
  // Write to lane zero takes effect this edge
  logic wr_go;
  // Read data mux result for the addressed location
  logic [31:0] rd_mux;
  // Slot memory bus read data
  cfg_byte_t slot_rd_a;
  // Slot memory active slot data
  cfg_byte_t slot_rd_b;
  // Three-stage pin synchroniser and filtered level
  logic [5:0] gin_s1_r;
  logic [5:0] gin_s2_r;
  logic [5:0] gin_s3_r;
  logic [5:0] gin_filt_r;
  // Active slot chosen for the next edge
  slot_idx_t slot_nxt;
  slot_idx_t active_slot_r;
  // Registered gated pins and external clock flag
  logic [5:0] gated_r;
  logic ext_clk_r;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign idx = paddr[7:2];
  assign xfer_done = psel && penable && pready_r;
  assign wr_go = xfer_done && pwrite && hit && pstrb[0];

  // Hit detection; misaligned or unknown addresses answer with error
  always_comb begin
    hit = 1'b0;
    slot_hit = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == `IDX_FREQ_CONTROL_MODE) begin
      hit = 1'b1;
    end else if (idx == `IDX_INPUT_PIN_GATES) begin
      hit = 1'b1;
    end else if (idx == `IDX_OSC_SWING_SELECT) begin
      hit = 1'b1;
    end else if (idx == `IDX_OSC_LOAD_TRIM) begin
      hit = 1'b1;
    end else if (idx >= `IDX_SLOT_ZERO && idx <= `IDX_SLOT_THREE) begin
      hit = 1'b1;
      slot_hit = 1'b1;
    end
  end

  // Read mux: full byte back including reserved bits, upper bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!hit) begin
      rd_mux = 32'h0000_0000;
    end else if (idx == `IDX_FREQ_CONTROL_MODE) begin
      rd_mux = {24'h00_0000, mode_r};
    end else if (idx == `IDX_INPUT_PIN_GATES) begin
      rd_mux = {24'h00_0000, gates_r};
    end else if (idx == `IDX_OSC_SWING_SELECT) begin
      rd_mux = {24'h00_0000, swing_r};
    end else if (idx == `IDX_OSC_LOAD_TRIM) begin
      rd_mux = {24'h00_0000, trim_r};
    end else if (slot_hit) begin
      rd_mux = {24'h00_0000, slot_rd_a};
    end
  end

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  // One wait state: slot memory reads are registered, so the data is
  // only settled in the first access cycle; pready follows one edge on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
    end else begin
      pready_r <= 1'b0;
    end
  end

  // Error flag rides with pready for unmapped or misaligned addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pslverr_r <= !hit;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // Read data captured as pready rises; zero outside read answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !pready_r && !pwrite) begin
      prdata_r <= rd_mux;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Plain configuration registers
  // ****************************************************************
  // Mode location; reserved bits stored as written, host keeps them zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `RST_FREQ_CONTROL_MODE;
    end else if (wr_go && idx == `IDX_FREQ_CONTROL_MODE) begin
      mode_r <= pwdata[7:0];
    end
  end

  // Gate location; reserved top bits are the host's to keep at one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates_r <= `RST_INPUT_PIN_GATES;
    end else if (wr_go && idx == `IDX_INPUT_PIN_GATES) begin
      gates_r <= pwdata[7:0];
    end
  end

  // Swing location; reserved bits are the host's to keep at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swing_r <= `RST_OSC_SWING_SELECT;
    end else if (wr_go && idx == `IDX_OSC_SWING_SELECT) begin
      swing_r <= pwdata[7:0];
    end
  end

  // Load trim; no interlock with the swing code, the host zeroes it
  // itself when it picks the external clock, so order of writes is free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_r <= `RST_OSC_LOAD_TRIM;
    end else if (wr_go && idx == `IDX_OSC_LOAD_TRIM) begin
      trim_r <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Loop filter slot store
  // ****************************************************************
  // Slot writes and both reads go through the small memory
  cfg_slot_mem u_slots (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_go && slot_hit),
    .wr_idx(idx[1:0]),
    .wr_data(pwdata[7:0]),
    .rd_idx_a(idx[1:0]),
    .rd_data_a_r(slot_rd_a),
    .rd_idx_b(slot_nxt),
    .rd_data_b_r(slot_rd_b)
  );

  // ****************************************************************
  // General input pin synchroniser
  // ****************************************************************
  // Three stages; only the second and third are compared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gin_s1_r <= 6'h00;
      gin_s2_r <= 6'h00;
      gin_s3_r <= 6'h00;
    end else begin
      gin_s1_r <= general_input_pins;
      gin_s2_r <= gin_s1_r;
      gin_s3_r <= gin_s2_r;
    end
  end

  // Filter: a pin change counts once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < `NUM_GIN; b++) begin : g_filt
      // Per-pin filtered level
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gin_filt_r[b] <= 1'b0;
        end else if (gin_s2_r[b] == gin_s3_r[b]) begin
          gin_filt_r[b] <= gin_s3_r[b];
        end
      end
    end
  endgenerate

  // Gating: a cleared gate disconnects the pin and holds it low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gated_r <= 6'h00;
    end else begin
      gated_r <= gin_filt_r & gates_r[`POS_GATE_MSB:`POS_GATE_LSB];
    end
  end

  // ****************************************************************
  // Active slot selection
  // ****************************************************************
  // In mode with all pins disconnected slot zero is forced; otherwise
  // the two lowest gated pins pick the slot
  always_comb begin
    slot_nxt = gated_r[1:0];
    if (mode_r[`POS_MODE_BIT] &&
        (gates_r[`POS_GATE_MSB:`POS_GATE_LSB] == 6'h00)) begin
      slot_nxt = `SLOT_ZERO_SEL;
    end
  end

  // Slot index registered in step with the memory's read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_slot_r <= `SLOT_ZERO_SEL;
    end else begin
      active_slot_r <= slot_nxt;
    end
  end

  // External clock flag follows the swing code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_r <= 1'b1;
    end else begin
      ext_clk_r <= (swing_r[`POS_SWING_MSB:`POS_SWING_LSB] ==
                    SWING_EXT_CLK);
    end
  end

  // ****************************************************************
  // Outputs, each straight from a flip-flop
  // ****************************************************************
  // Bus answer
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  // Pins and mode
  assign gated_input_pins = gated_r;
  assign manual_freq_select_mode = mode_r[`POS_MODE_BIT];
  assign input_pin_gate = gates_r[`POS_GATE_MSB:`POS_GATE_LSB];
  // Oscillator; the analog side turns codes into swing and capacitance
  assign osc_swing_select =
    osc_swing_t'(swing_r[`POS_SWING_MSB:`POS_SWING_LSB]);
  assign osc_ext_clock_sel = ext_clk_r;
  assign osc_load_trim = trim_r;
  // Loop controls from the active slot, one edge after the slot or its contents change
  assign active_slot = active_slot_r;
  assign out_divider_choice = slot_rd_b[`POS_ODIV_BIT];
  assign pump_current_code =
    slot_rd_b[`POS_PUMP_MSB:`POS_PUMP_LSB];
  assign loop_resistor_code =
    slot_rd_b[`POS_RES_MSB:`POS_RES_LSB];

endmodule

`default_nettype wire

/* File: sim/cfg_regs_checker.sv */
// Port checker for the loop cfg register bank.
// Assumes the bank's top module ports, bound below.
`default_nettype none

module cfg_regs_checker
  import pll_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Controls
  input wire logic [5:0] gated_input_pins,
  input wire logic manual_freq_select_mode,
  input wire logic [5:0] input_pin_gate,
  input wire pll_cfg_pkg::osc_swing_t osc_swing_select,
  input wire logic osc_ext_clock_sel,
  input wire logic [7:0] osc_load_trim,
  input wire pll_cfg_pkg::slot_idx_t active_slot
);
  // ****
  // Helpers
  // ****
  // Write that lands, and an address outside the bank
  wire logic wr_ok = psel & penable & pready & pwrite & pstrb[0];
  wire logic bad = (paddr[7:2] < 6'h04) | (paddr[7:2] > 6'h0b)
    | (paddr[1:0] != 2'h0);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One wait state, then a one-cycle answer
  property p_wait; $rose(penable) && psel |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  // Errors only for holes and misaligned addresses, with zero data
  property p_err;
    pready |-> (pslverr == bad) && (!pslverr || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper set");
  // Field writes reach the outputs one edge later
  property p_mode; wr_ok && paddr == 8'h10
    |=> manual_freq_select_mode == $past(pwdata[0]); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_gate; wr_ok && paddr == 8'h14
    |=> input_pin_gate == $past(pwdata[5:0]); endproperty
  a_gate: assert property (p_gate) else $error("gates");
  property p_swing; wr_ok && paddr == 8'h18
    |=> osc_swing_select == $past(pwdata[5:4]); endproperty
  a_swing: assert property (p_swing) else $error("swing");
  property p_trim; wr_ok && paddr == 8'h1c
    |=> osc_load_trim == $past(pwdata[7:0]); endproperty
  a_trim: assert property (p_trim) else $error("trim");
  // Zero strobe leaves trim and gates alone
  property p_nostrb; psel && penable && pready && pwrite && !pstrb[0]
    |=> $stable(osc_load_trim) && $stable(input_pin_gate); endproperty
  a_nostrb: assert property (p_nostrb) else $error("strobe");
  property p_ext; 1'b1 |=> osc_ext_clock_sel
    == ($past(osc_swing_select) == SWING_EXT_CLK); endproperty
  a_ext: assert property (p_ext) else $error("ext clock");
  property p_gate_off;
    (input_pin_gate == 6'h00) [*2] |-> gated_input_pins == 6'h00;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("pin");
  property p_slot0; (manual_freq_select_mode && input_pin_gate == 6'h00)
    [*3] |-> active_slot == 2'h0; endproperty
  a_slot0: assert property (p_slot0) else $error("slot");

  // Main scenarios seen
  c_wr: cover property (wr_ok);
  c_err: cover property (pready && pslverr);
  c_slot0: cover property (manual_freq_select_mode && input_pin_gate == 0);
endmodule

bind pll_input_and_loop_cfg_regs cfg_regs_checker chk_u (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .gated_input_pins, .manual_freq_select_mode, .input_pin_gate,
  .osc_swing_select, .osc_ext_clock_sel, .osc_load_trim, .active_slot);

`default_nettype wire

/* File: sim/test_pll_input_and_loop_cfg_regs.sv */
// Self-checking bench for the loop cfg register bank.
// Assumes APB answers in bounded time; pins settle in a few edges.
`default_nettype none

module test_pll_input_and_loop_cfg_regs import pll_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench drives and design outputs
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [5:0] general_input_pins = 6'h00, gated_input_pins, input_pin_gate;
  logic pready, pslverr, manual_freq_select_mode, osc_ext_clock_sel, er;
  logic out_divider_choice;
  osc_swing_t osc_swing_select;
  logic [7:0] osc_load_trim;
  slot_idx_t active_slot;
  logic [2:0] pump_current_code;
  logic [3:0] loop_resistor_code;
  int fails = 0, cmp_count = 0;
  wire logic [7:0] loop_now = {out_divider_choice, pump_current_code,
    loop_resistor_code};
  wire logic [7:0] misc = {4'h0, manual_freq_select_mode,
    osc_ext_clock_sel, osc_swing_select};
  // Row: address, write word, expected readback
  typedef struct packed {logic [7:0] a; logic [31:0] d, q;} row_t;
  row_t rows [8] = '{'{8'h10, 32'h5a5a5a01, 32'h01},
    '{8'h14, 32'h5a5a5ad5, 32'hd5}, '{8'h18, 32'h5a5a5a20, 32'h20},
    '{8'h1c, 32'h5a5a5aa7, 32'ha7}, '{8'h20, 32'h5a5a5a9c, 32'h9c},
    '{8'h24, 32'h5a5a5a7f, 32'h7f}, '{8'h28, 32'h5a5a5ae1, 32'he1},
    '{8'h2c, 32'h5a5a5a53, 32'h53}};
  logic [7:0] rst_val [8] = '{8'h00, 8'hff, 8'h30, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};

  pll_input_and_loop_cfg_regs dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .general_input_pins, .gated_input_pins, .manual_freq_select_mode,
    .input_pin_gate, .osc_swing_select, .osc_ext_clock_sel, .osc_load_trim,
    .active_slot, .out_divider_choice, .pump_current_code,
    .loop_resistor_code);

  // 50 MHz clock
  initial begin
    forever #10 pclk = ~pclk;
  end

  // ****
  // Tasks
  // ****
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Port values are widened to a word
  task automatic chk_port(input logic [7:0] g, input logic [7:0] e);
    chk_word({24'h0, g}, {24'h0, e});
  endtask
  // One APB transfer, entered just after an edge; idle edge after it
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No wait count assumed; only the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
    input logic ee);
    // Reads carry no byte strobe
    apb(1'b0, a, 32'h0, 4'h0);
    chk_word(rd, e);
    chk_port({7'h0, er}, {7'h0, ee});
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 20 us
  initial begin
    #100000;
    fails++;
    test_done();
  end

  // ****
  // Sequence
  // ****
  initial begin
    repeat (3) @(posedge pclk);
    chk_port(misc, 8'h07);
    chk_port({2'h0, input_pin_gate}, 8'h3f);
    chk_port(osc_load_trim, 8'h00);
    chk_port(loop_now, 8'h00);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdchk(8'h10 + 8'(i * 4), {24'h0, rst_val[i]}, 1'b0);
    end
    // Table rows: write, then read back the low byte
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, 4'hf);
      rdchk(rows[i].a, rows[i].q, 1'b0);
    end
    chk_port(misc, 8'h0a);
    chk_port({2'h0, input_pin_gate}, 8'h15);
    chk_port(osc_load_trim, 8'ha7);
    // External clock code needs a zero trim first
    apb(1'b1, 8'h1c, 32'h0, 4'hf);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h18, 32'(c * 16), 4'hf);
      // External clock flag is registered one edge after the swing code
      @(posedge pclk);
      chk_port(misc, {5'h01, c == 3, 2'(c)});
    end
    // Slot chosen by gated pins; a closed gate forces the pin low
    general_input_pins <= 6'h03;
    repeat (10) @(posedge pclk);
    chk_port({2'h0, gated_input_pins}, 8'h01);
    chk_port(loop_now, 8'h7f);
    chk_port({6'h0, active_slot}, 8'h01);
    apb(1'b1, 8'h14, 32'hc0, 4'hf);
    repeat (4) @(posedge pclk);
    chk_port(loop_now, 8'h9c);
    chk_port({6'h0, active_slot}, 8'h00);
    apb(1'b1, 8'h14, 32'hff, 4'hf);
    repeat (10) @(posedge pclk);
    chk_port(loop_now, 8'h53);
    chk_port({6'h0, active_slot}, 8'h03);
    apb(1'b1, 8'h2c, 32'h2a, 4'hf);
    repeat (3) @(posedge pclk);
    chk_port(loop_now, 8'h2a);
    // Holes, misalignment and a zero strobe
    rdchk(8'h0c, 32'h0, 1'b1);
    rdchk(8'h30, 32'h0, 1'b1);
    apb(1'b1, 8'h11, 32'hff, 4'hf);
    chk_port({7'h0, er}, 8'h01);
    rdchk(8'h10, 32'h01, 1'b0);
    apb(1'b1, 8'h1c, 32'h33, 4'h0);
    rdchk(8'h1c, 32'h00, 1'b0);
    // Reset in mid-run restores the defaults
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h14, 32'hff, 1'b0);
    rdchk(8'h2c, 32'h00, 1'b0);
    chk_port(misc, 8'h07);
    test_done();
  end
endmodule

`default_nettype wire
